//--- rtl/ldd_dev.sv
`timescale 1ns/1ns
module ldd_dev
	import ldd_pkg::*;
#(
	parameter ldd_var_t VARIANT = LDD_VAR_CTRLWORD,
	parameter int       DIG_CYC = DIGIT_CYC,
	parameter int       BLK_CYC = BLANK_CYC
) (
	input  wire logic          clk,        // system clock
	input  wire logic          srst,       // sync reset
	ldd_if.dev                 bus,        // host side pins
	output logic [DIGITS-1:0]  digit_on,   // digit drivers, high on
	output logic [7:0]         seg_on      // {dp,g,f,e,d,c,b,a}, high on
);
	import ldd_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem_r [DIGITS];
	logic [7:0]        cw_r;
	logic [ADDR_W:0]   seq_r;              // words left to accept
	logic              wr_q_r;
	logic              strobe;
	ldd_mode_t         mode_now;
	logic [ADDR_W-1:0] scan_digit;
	logic              scan_blank;
	logic [7:0]        cur;
	logic [7:0]        pat;

	// strobe is the falling edge of the write line
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q_r <= 1'b1;
		end else begin
			wr_q_r <= bus.write_n;
		end
	end
	assign strobe = wr_q_r && !bus.write_n;

	// ----------------------------------------------------------------
	// control word and sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cw_r  <= CW_RST;
			seq_r <= '0;
		end else if (VARIANT == LDD_VAR_CTRLWORD && strobe) begin
			if (bus.mode) begin
				cw_r  <= bus.input_data_bits;
				seq_r <= bus.input_data_bits[CW_FOLLOW_BIT] ? (ADDR_W+1)'(DIGITS) : '0;
			end else if (seq_r != '0) begin
				seq_r <= seq_r - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// memory writes, also in shutdown
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (strobe) begin
			if (VARIANT == LDD_VAR_CTRLWORD) begin
				// no addressing here: only the running sequence writes
				if (!bus.mode && seq_r != '0) begin
					mem_r[ADDR_W'(DIGITS - seq_r)] <= bus.input_data_bits;
				end
			end else begin
				mem_r[bus.digit_select_bits] <= bus.input_data_bits;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode selection
	// ----------------------------------------------------------------
	always_comb begin
		mode_now = LDD_HEX;
		unique case (VARIANT)
			LDD_VAR_CTRLWORD: begin
				if (!cw_r[CW_RUN_BIT])     mode_now = LDD_SHUT;
				else if (cw_r[CW_RAW_BIT]) mode_now = LDD_RAW;
				else if (cw_r[CW_HEX_BIT]) mode_now = LDD_HEX;
				else                       mode_now = LDD_SYM;
			end
			LDD_VAR_TRI: begin
				unique case (bus.tri_level)
					LDD_TRI_HIGH:  mode_now = LDD_HEX;
					LDD_TRI_FLOAT: mode_now = LDD_SYM;
					default:       mode_now = LDD_SHUT;
				endcase
			end
			default: begin
				if (!bus.shutdown_n)    mode_now = LDD_SHUT;
				else if (bus.no_decode) mode_now = LDD_RAW;
				else if (bus.decode_type) mode_now = LDD_SYM;
				else                    mode_now = LDD_HEX;
			end
		endcase
	end

	ldd_scan #(
		.DIG_CYC (DIG_CYC),
		.BLK_CYC (BLK_CYC)
	) u_scan (
		.clk   (clk),
		.srst  (srst),
		.run   (mode_now != LDD_SHUT),
		.digit (scan_digit),
		.blank (scan_blank)
	);

	// ----------------------------------------------------------------
	// segment pattern
	// ----------------------------------------------------------------
	always_comb begin
		cur = mem_r[scan_digit];
		pat = SEG_OFF;
		unique case (mode_now)
			LDD_RAW: begin
				// bits 6..0 = a,b,c,e,g,f,d
				pat = {!cur[DP_BIT], cur[2], cur[1], cur[3], cur[0], cur[4], cur[5], cur[6]};
			end
			LDD_HEX: pat = ldd_decode(cur[3:0], 1'b0) | {!cur[DP_BIT], 7'h00};
			LDD_SYM: pat = ldd_decode(cur[3:0], 1'b1) | {!cur[DP_BIT], 7'h00};
			default: pat = SEG_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			digit_on <= '0;
			seg_on   <= SEG_OFF;
		end else if (mode_now == LDD_SHUT || scan_blank) begin
			digit_on <= '0;
			seg_on   <= SEG_OFF;
		end else begin
			digit_on <= DIGITS'(1) << scan_digit;
			seg_on   <= pat;
		end
	end
endmodule // ldd_dev

//--- rtl/ldd_host.sv
`timescale 1ns/1ns
module ldd_host
	import ldd_pkg::*;
#(
	parameter ldd_var_t VARIANT  = LDD_VAR_CTRLWORD,
	parameter int       HOLD_CYC = 8   // strobe low and high widths (>=400ns)
) (
	input  wire logic              clk,      // system clock
	input  wire logic              srst,     // sync reset
	input  wire logic              req,      // pulse: start a write
	input  wire logic              is_ctrl,  // request is a control word
	input  wire logic [DATA_W-1:0] wdata,    // word to write
	input  wire logic [ADDR_W-1:0] waddr,    // digit for addressed variants
	input  wire ldd_tri_t          tri_in,   // three-level setting
	input  wire logic              dtype_in, // high numeric-symbol
	input  wire logic              raw_in,   // high raw
	input  wire logic              run_in,   // low shuts down
	output logic                   busy,     // write in progress
	ldd_if.host                    bus       // device pins
);
	import ldd_pkg::*;
	typedef enum logic [1:0] {LDH_IDLE, LDH_SETUP, LDH_LOW, LDH_HIGH} ldh_st_t;
	localparam int HW = $clog2(HOLD_CYC + 1);

	ldh_st_t       st_r;
	logic [HW-1:0] cnt_r;

	// ----------------------------------------------------------------
	// write cycle: setup, strobe low, recovery high
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r                  <= LDH_IDLE;
			cnt_r                 <= '0;
			bus.write_n           <= 1'b1;
			bus.mode              <= 1'b0;
			bus.input_data_bits   <= '0;
			bus.digit_select_bits <= '0;
			busy                  <= 1'b0;
		end else begin
			unique case (st_r)
				LDH_IDLE: begin
					bus.write_n <= 1'b1;
					if (req) begin
						bus.input_data_bits   <= wdata;
						bus.digit_select_bits <= waddr;
						bus.mode  <= (VARIANT == LDD_VAR_CTRLWORD) && is_ctrl;
						busy      <= 1'b1;
						cnt_r     <= '0;
						st_r      <= LDH_SETUP;
					end
				end
				LDH_SETUP: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == HW'(HOLD_CYC - 1)) begin
						bus.write_n <= 1'b0;
						cnt_r <= '0;
						st_r  <= LDH_LOW;
					end
				end
				LDH_LOW: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == HW'(HOLD_CYC - 1)) begin
						bus.write_n <= 1'b1;
						cnt_r <= '0;
						st_r  <= LDH_HIGH;
					end
				end
				LDH_HIGH: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == HW'(HOLD_CYC - 1)) begin
						busy <= 1'b0;
						st_r <= LDH_IDLE;
					end
				end
			endcase
		end
	end

	// static controls follow their inputs continuously
	always_ff @(posedge clk) begin
		if (srst) begin
			bus.tri_level   <= LDD_TRI_HIGH;
			bus.decode_type <= 1'b0;
			bus.no_decode   <= 1'b0;
			bus.shutdown_n  <= 1'b1;
		end else begin
			bus.tri_level   <= tri_in;
			bus.decode_type <= dtype_in;
			bus.no_decode   <= raw_in;
			bus.shutdown_n  <= run_in;
		end
	end
endmodule // ldd_host

//--- rtl/ldd_if.sv
`timescale 1ns/1ns
interface ldd_if;
	import ldd_pkg::*;
	logic                write_n;       // write strobe, low loads
	logic                mode;          // high: control word
	logic [DATA_W-1:0]   input_data_bits;
	logic [ADDR_W-1:0]   digit_select_bits;
	ldd_tri_t            tri_level;     // three-level control
	logic                decode_type;   // high numeric-symbol
	logic                no_decode;     // high raw
	logic                shutdown_n;    // low shuts down

	modport dev  (input write_n, mode, input_data_bits, digit_select_bits,
	              tri_level, decode_type, no_decode, shutdown_n);
	modport host (output write_n, mode, input_data_bits, digit_select_bits,
	              tri_level, decode_type, no_decode, shutdown_n);
endinterface

//--- rtl/ldd_pkg.sv
package ldd_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 20_000_000;
	localparam int SCAN_HZ         = 250;
	localparam int BLANK_NS        = 10_000;
	localparam int CLK_NS          = 50;
	localparam int BLANK_CYC       = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIGIT_CYC       = CLK_HZ / (SCAN_HZ * 8);

	// ----------------------------------------------------------------
	// memory and fields
	// ----------------------------------------------------------------
	localparam int DIGITS          = 8;
	localparam int ADDR_W          = 3;
	localparam int DATA_W          = 8;
	localparam int DP_BIT          = 7;
	localparam int CW_FOLLOW_BIT   = 7;
	localparam int CW_HEX_BIT      = 6;
	localparam int CW_RAW_BIT      = 5;
	localparam int CW_RUN_BIT      = 4;
	localparam logic [7:0] SEG_OFF = 8'h00;
	localparam logic [7:0] CW_RST  = 8'h50;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {LDD_HEX, LDD_SYM, LDD_RAW, LDD_SHUT} ldd_mode_t;
	typedef enum logic [1:0] {LDD_VAR_CTRLWORD, LDD_VAR_TRI, LDD_VAR_LINES} ldd_var_t;
	typedef enum logic [1:0] {LDD_TRI_LOW, LDD_TRI_FLOAT, LDD_TRI_HIGH} ldd_tri_t;

	// segment pattern {dp,g,f,e,d,c,b,a}, positive true
	function automatic logic [7:0] ldd_decode(input logic [3:0] code, input logic sym);
		logic [6:0] s;
		s = 7'h00;
		if (!sym) begin
			unique case (code)
				4'h0: s = 7'h3F;  4'h1: s = 7'h06;  4'h2: s = 7'h5B;  4'h3: s = 7'h4F;
				4'h4: s = 7'h66;  4'h5: s = 7'h6D;  4'h6: s = 7'h7D;  4'h7: s = 7'h07;
				4'h8: s = 7'h7F;  4'h9: s = 7'h6F;  4'hA: s = 7'h77;  4'hB: s = 7'h7C;
				4'hC: s = 7'h39;  4'hD: s = 7'h5E;  4'hE: s = 7'h79;  4'hF: s = 7'h71;
			endcase
		end else begin
			unique case (code)
				4'h0: s = 7'h3F;  4'h1: s = 7'h06;  4'h2: s = 7'h5B;  4'h3: s = 7'h4F;
				4'h4: s = 7'h66;  4'h5: s = 7'h6D;  4'h6: s = 7'h7D;  4'h7: s = 7'h07;
				4'h8: s = 7'h7F;  4'h9: s = 7'h6F;  4'hA: s = 7'h40;  4'hB: s = 7'h79;
				4'hC: s = 7'h76;  4'hD: s = 7'h38;  4'hE: s = 7'h73;  4'hF: s = 7'h00;
			endcase
		end
		return {1'b0, s};
	endfunction

endpackage

//--- rtl/ldd_scan.sv
`timescale 1ns/1ns
module ldd_scan
	import ldd_pkg::*;
#(
	parameter int DIG_CYC = DIGIT_CYC,
	parameter int BLK_CYC = BLANK_CYC
) (
	input  wire logic              clk,      // system clock
	input  wire logic              srst,     // sync reset
	input  wire logic              run,      // low halts oscillator
	output logic [ADDR_W-1:0]      digit,    // digit being scanned
	output logic                   blank     // inter-digit blank
);
	localparam int CW = $clog2(DIG_CYC + 1);
	logic [CW-1:0] cnt_r;

	// ----------------------------------------------------------------
	// scan oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
			digit <= '0;
		end else if (run) begin
			if (cnt_r == CW'(DIG_CYC - 1)) begin
				cnt_r <= '0;
				digit <= digit + 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// first part of each slot is dark so segments settle
	always_ff @(posedge clk) begin
		if (srst) begin
			blank <= 1'b1;
		end else begin
			blank <= !run || (cnt_r == CW'(DIG_CYC - 1)) || (cnt_r < CW'(BLK_CYC - 1));
		end
	end
endmodule // ldd_scan

//--- tb/ldd_checker.sv
`timescale 1ns/1ns
module ldd_checker (
	input  wire logic       clk,               // system clock
	input  wire logic       srst,              // sync reset
	input  wire logic       write_n,           // strobe from host
	input  wire logic       mode,              // control-word select
	input  wire logic [7:0] input_data_bits,   // bus data
	input  wire logic [2:0] digit_select_bits, // digit address
	input  wire logic [7:0] digit_on,          // digit drivers
	input  wire logic [7:0] seg_on             // segment drivers
);
	// ----------------------------------------------------------------
	// helper: last digit that was lit
	// ----------------------------------------------------------------
	logic [7:0] last_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			last_r <= 8'h00;
		end else if (|digit_on) begin
			last_r <= digit_on;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// host side
	// ----------------------------------------------------------------
	a_strobe_low_width: assert property ($fell(write_n) |-> (!write_n)[*8] ##1 write_n)
		else $error("write strobe low width wrong");
	a_strobe_high_gap: assert property ($rose(write_n) |-> write_n[*8])
		else $error("write strobe high gap too short");
	a_bus_held_steady: assert property (!write_n |->
		$stable(input_data_bits) && $stable(mode) && $stable(digit_select_bits))
		else $error("bus changed while strobe low");

	// ----------------------------------------------------------------
	// device side
	// ----------------------------------------------------------------
	a_shut_goes_dark: assert property (($fell(write_n) && mode && !input_data_bits[4]) |->
		##2 (digit_on == 8'h00 && seg_on == 8'h00)[*8])
		else $error("drivers lit after shutdown word");
	a_one_digit: assert property ($onehot0(digit_on))
		else $error("more than one digit driven");
	a_blank_gap: assert property ($rose(|digit_on) |-> $past(digit_on, 1) == 8'h00
		&& $past(digit_on, 2) == 8'h00 && $past(digit_on, 3) == 8'h00)
		else $error("inter-digit blank too short");
	a_dark_segs: assert property (digit_on == 8'h00 |-> seg_on == 8'h00)
		else $error("segments lit with no digit");
	a_digit_dwell: assert property ($rose(|digit_on) |=>
		($stable(digit_on) || digit_on == 8'h00)[*8])
		else $error("digit slot too short");
	// resume after shutdown may relight the frozen digit
	a_scan_order: assert property (($rose(|digit_on) && last_r != 8'h00) |->
		(digit_on == {last_r[6:0], last_r[7]} || digit_on == last_r))
		else $error("scan skipped a digit");
endmodule // ldd_checker

//--- tb/ldd_tb.sv
`timescale 1ns/1ns
module ldd_tb;
	import ldd_pkg::*;
	typedef struct packed {logic [7:0] cw; logic [7:0] dat; logic [7:0] seg;} ldd_row_t;

	logic       clk     = 1'b0;
	logic       srst    = 1'b1;
	logic       req     = 1'b0;
	logic       is_ctrl = 1'b0;
	logic [7:0] wdata   = 8'h00;
	logic [2:0] waddr   = 3'h7;
	logic [7:0] lit;
	logic       busy;
	logic [7:0] digit_on;
	logic [7:0] seg_on;
	logic       req2     = 1'b0;
	logic       dtype2   = 1'b0;
	logic       raw2     = 1'b0;
	logic       run2     = 1'b1;
	logic       busy2;
	logic [7:0] digit2;
	logic [7:0] seg2;
	int         n_errors = 0;
	int         checks   = 0;
	int         i;
	// ----------------------------------------------------------------
	// rows: control word, data word, expected segments
	// ----------------------------------------------------------------
	ldd_row_t   rows [10] = '{
		'{8'hD0, 8'h85, 8'h6D}, '{8'hD0, 8'h0F, 8'hF1}, '{8'hD0, 8'h8A, 8'h77},
		'{8'hD0, 8'h80, 8'h3F}, '{8'h90, 8'h8A, 8'h40}, '{8'h90, 8'h8F, 8'h00},
		'{8'h90, 8'h0F, 8'h80}, '{8'h90, 8'h8C, 8'h76}, '{8'hB0, 8'h84, 8'h40},
		'{8'hB0, 8'h7F, 8'hFF}};

	always #25 clk = ~clk;

	ldd_if u_ldd_if ();

	ldd_host #(.VARIANT(LDD_VAR_CTRLWORD)) u_ldd_host (
		.clk(clk), .srst(srst), .req(req), .is_ctrl(is_ctrl), .wdata(wdata),
		.waddr(waddr), .tri_in(LDD_TRI_HIGH), .dtype_in(1'b0), .raw_in(1'b0),
		.run_in(1'b1), .busy(busy), .bus(u_ldd_if));

	// short scan keeps the run brief
	ldd_dev #(.VARIANT(LDD_VAR_CTRLWORD), .DIG_CYC(20), .BLK_CYC(4)) u_ldd_dev (
		.clk(clk), .srst(srst), .bus(u_ldd_if), .digit_on(digit_on), .seg_on(seg_on));

	// addressed variant with separate control lines
	ldd_if u_ldd_if_b ();

	ldd_host #(.VARIANT(LDD_VAR_LINES)) u_ldd_host_b (
		.clk(clk), .srst(srst), .req(req2), .is_ctrl(1'b0), .wdata(wdata),
		.waddr(waddr), .tri_in(LDD_TRI_HIGH), .dtype_in(dtype2), .raw_in(raw2),
		.run_in(run2), .busy(busy2), .bus(u_ldd_if_b));

	ldd_dev #(.VARIANT(LDD_VAR_LINES), .DIG_CYC(20), .BLK_CYC(4)) u_ldd_dev_b (
		.clk(clk), .srst(srst), .bus(u_ldd_if_b), .digit_on(digit2), .seg_on(seg2));

	ldd_checker u_ldd_checker (
		.clk(clk), .srst(srst), .write_n(u_ldd_if.write_n), .mode(u_ldd_if.mode),
		.input_data_bits(u_ldd_if.input_data_bits),
		.digit_select_bits(u_ldd_if.digit_select_bits),
		.digit_on(digit_on), .seg_on(seg_on));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] raw2seg(input logic [7:0] d);
		return {~d[7], d[2], d[1], d[3], d[0], d[4], d[5], d[6]};
	endfunction

	task automatic cmp8(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic c, input logic [7:0] d);
		int k;
		@(negedge clk);
		req = 1'b1;
		is_ctrl = c;
		wdata = d;
		@(negedge clk);
		req = 1'b0;
		for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
	endtask

	task automatic wr2(input logic [2:0] a, input logic [7:0] d);
		int k;
		@(negedge clk);
		req2 = 1'b1;
		waddr = a;
		wdata = d;
		@(negedge clk);
		req2 = 1'b0;
		for (k = 0; k < 100 && busy2 !== 1'b0; k++) @(negedge clk);
	endtask

	task automatic see2(input int d, input logic [7:0] exp);
		int k;
		for (k = 0; k < 400 && digit2 !== (8'h01 << d); k++) @(negedge clk);
		cmp8("digit2", digit2, 8'h01 << d);
		cmp8("seg2", seg2, exp);
	endtask

	// waits for the digit's slot, bounded by 400 cycles, two and a half scans
	task automatic see(input int d, input logic [7:0] exp);
		int k;
		for (k = 0; k < 400 && digit_on !== (8'h01 << d); k++) @(negedge clk);
		cmp8("digit_on", digit_on, 8'h01 << d);
		cmp8("seg_on", seg_on, exp);
	endtask

	task automatic give_verdict();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		cmp8("reset digit_on", digit_on, 8'h00);
		cmp8("reset seg_on", seg_on, 8'h00);
		cmp8("reset busy", {7'h00, busy}, 8'h00);
		foreach (rows[r]) begin
			wr(1'b1, rows[r].cw);
			repeat (8) wr(1'b0, rows[r].dat);
			see(r % 8, rows[r].seg);
		end
		// addresses vary but must not steer the auto sequence
		wr(1'b1, 8'hB0);
		for (i = 0; i < 9; i++) begin
			waddr = 3'(7 - i);
			wr(1'b0, (i < 8) ? (8'h80 ^ (8'h01 << i)) : 8'h7F);
		end
		for (i = 0; i < 8; i++) begin
			see(i, raw2seg(8'h80 ^ (8'h01 << i)));
		end
		wr(1'b1, 8'h30);
		wr(1'b0, 8'h7F);
		see(0, raw2seg(8'h81));
		wr(1'b1, 8'hA0);
		repeat (8) wr(1'b0, 8'h7F);
		lit = 8'h00;
		repeat (200) begin
			@(negedge clk);
			lit = lit | digit_on | seg_on;
		end
		cmp8("shutdown lit", lit, 8'h00);
		wr(1'b1, 8'h30);
		see(5, 8'hFF);
		raw2 = 1'b1;
		wr2(3'h3, 8'h7F);
		wr2(3'h6, 8'h84);
		see2(3, 8'hFF);
		see2(6, 8'h40);
		raw2 = 1'b0;
		dtype2 = 1'b1;
		repeat (2) @(negedge clk);
		see2(6, 8'h66);
		dtype2 = 1'b0;
		wr2(3'h3, 8'h0E);
		see2(3, 8'hF9);
		run2 = 1'b0;
		wr2(3'h2, 8'h7F);
		lit = 8'h00;
		repeat (100) begin
			@(negedge clk);
			lit = lit | digit2 | seg2;
		end
		cmp8("lines shutdown lit", lit, 8'h00);
		run2 = 1'b1;
		raw2 = 1'b1;
		see2(2, 8'hFF);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
endmodule // ldd_tb
